// >>> logic/band_alarm_pkg.sv
// Offsets, field positions, reset values and carriers for the spectral band alarm monitor.
package band_alarm_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int BANDS = 6;
    localparam int RATES = 4;

    // ------------------------------------------------------------
    // Register indexes; the byte address is four times the index
    // ------------------------------------------------------------
    localparam logic [6:0] IDX_LOWER_BIN = 7'h20;
    localparam logic [6:0] IDX_UPPER_BIN = 7'h22;
    localparam logic [6:0] IDX_X_WARN = 7'h24;
    localparam logic [6:0] IDX_Y_WARN = 7'h26;
    localparam logic [6:0] IDX_X_FAULT = 7'h28;
    localparam logic [6:0] IDX_Y_FAULT = 7'h2A;
    localparam logic [6:0] IDX_SELECTOR = 7'h2C;
    localparam logic [6:0] IDX_SYS_LEVEL = 7'h2E;
    localparam logic [6:0] IDX_CONFIG = 7'h30;
    localparam logic [6:0] IDX_DIAG = 7'h34;
    localparam logic [6:0] IDX_COMMAND = 7'h36;
    localparam logic [6:0] IDX_X_FLAGS = 7'h38;
    localparam logic [6:0] IDX_Y_FLAGS = 7'h3A;
    localparam logic [6:0] IDX_X_PEAK = 7'h3C;
    localparam logic [6:0] IDX_Y_PEAK = 7'h3E;
    localparam logic [6:0] IDX_X_BIN = 7'h44;
    localparam logic [6:0] IDX_Y_BIN = 7'h46;
    localparam logic [6:0] IDX_PIN_SELECT = 7'h50;

    // ------------------------------------------------------------
    // Fields and reset values
    // ------------------------------------------------------------
    localparam logic [15:0] CONFIG_RESET = 16'h0080;
    localparam logic [15:0] CONFIG_MASK = 16'h0FFB;
    localparam int CFG_X_EN = 0;
    localparam int CFG_SYS_EN = 3;
    localparam int CFG_SYS_TEMP = 4;
    localparam int CFG_SYS_LESS = 5;
    localparam int CFG_PINS = 6;
    localparam int CFG_DELAY_LSB = 8;
    localparam int CMD_CLEAR = 9;
    localparam int CMD_SAVE = 12;
    localparam int SEL_RATE_LSB = 8;
    localparam int PIN_WARN_LSB = 0;
    localparam int PIN_FAULT_LSB = 3;
    localparam logic [2:0] PIN_FUNC_ALARM = 3'h1;
    localparam logic [11:0] ALARM1_BITS = 12'h555;
    localparam logic [11:0] ALARM2_BITS = 12'hAAA;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic valid;
        logic [7:0] index;
        logic [15:0] x_mag;
        logic [15:0] y_mag;
    } bin_in_t;

    typedef struct packed {
        logic [15:0] diag;
        logic [15:0] x_flags;
        logic [15:0] y_flags;
        logic [15:0] x_peak;
        logic [15:0] y_peak;
        logic [7:0] x_bin;
        logic [7:0] y_bin;
    } header_t;

endpackage

// >>> logic/spectral_band_alarm_monitor.sv
// Spectral band alarm monitor with its register file on an Avalon-MM slave.
// How it works
// - Each axis holds a warning and a fault level, checked per band.
// - Levels use the same scaling as the incoming accelerometer magnitudes.
// - Axis level registers are 16-bit, read/write, reset to zero.
// - System level compares against temperature or supply, picked by config bit 4.
// - The clear command erases all band settings before new definitions.
// - The save command commits the alarm settings to nonvolatile storage.
// - A save is ignored when storage was already written since the last clear.
// - With pin function selected and config bit 6 set, pins show warning and fault.
// - Each record header carries diagnostic flags, band flags, peaks and bins.
// - Status bits 15 to 4 hold fault and warning pairs for bands 6 to 1.
// - Status bits 2 to 0 name the most critical band; bit 3 reads zero.
// - Band flags use only the bands of the current sample rate option.
// - Peak registers are read-only, reset to zero, worst-case magnitude.
// - Bin registers are read-only, worst-case bin in bits 7 to 0.
// - A band flag sets only after the response delay in consecutive records.
// - Config bit 0 enables the x axis and bit 1 the y axis.
// - Each band has 8-bit lower and upper bins per band and rate option.
`timescale 1ns/1ps

module spectral_band_alarm_monitor
    import band_alarm_pkg::*;
(
    // Clock and reset.
    input wire logic clock,
    input wire logic rst,
    // Avalon-MM register slave.
    input wire logic [8:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    // Spectral and measurement input.
    input wire bin_in_t spectrum,
    input wire logic record_end,
    input wire logic [1:0] rate_option,
    input wire logic [15:0] temperature,
    input wire logic [15:0] supply,
    // Record header and storage strobes.
    output header_t header,
    output logic header_valid,
    output logic nv_erase,
    output logic nv_commit,
    // Alarm indicators.
    output logic warning_pin,
    output logic fault_pin,
    output logic system_alarm
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
        logic [1:0][15:0] warn, fault;
        logic [15:0] sys_level;
        logic [2:0] sel_band;
        logic [1:0] sel_rate;
        logic [15:0] cfg;
        logic [5:0] pin_sel;
        logic [RATES-1:0][BANDS-1:0][7:0] lower, upper;
        logic nv_written, save_ignored, erase, commit;
        logic [1:0][BANDS-1:0][15:0] run_max;
        logic [1:0][BANDS-1:0][7:0] run_bin;
        logic [1:0][BANDS-1:0][1:0][3:0] persist;
        logic [1:0][15:0] flags, peak;
        logic [1:0][7:0] wbin;
        logic sys_alarm, hdr_valid, warn_pin, fault_pin;
    } state_t;

    localparam state_t STATE_RESET = '{cfg: CONFIG_RESET, default: '0};

    state_t q, d;
    logic [6:0] idx;
    logic [31:0] rd;
    logic [15:0] tmp, mag, mx, bpk, fl, sys_val, diag_word;
    logic [7:0] bn, bbin;
    logic [2:0] bsel, bband;
    logic sel_ok, hit1, hit2, a1, a2, found, best2;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                            input logic [3:0] be);
        merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
    endfunction
    function automatic logic in_band(input logic [7:0] bin, input logic [7:0] lo,
                                     input logic [7:0] hi);
        in_band = (bin >= lo) && (bin <= hi);
    endfunction
    function automatic logic [3:0] persist_next(input logic hit, input logic [3:0] cnt);
        persist_next = !hit ? 4'h0 : ((cnt == 4'hF) ? cnt : cnt + 4'h1);
    endfunction
    assign idx = address[8:2];
    assign diag_word = {14'h0000, q.save_ignored, q.sys_alarm};

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        d = q;
        rd = 32'h0000_0000;
        tmp = 16'h0000;
        hit1 = 1'b0;
        hit2 = 1'b0;
        a1 = 1'b0;
        a2 = 1'b0;
        sys_val = 16'h0000;
        d.erase = 1'b0;
        d.commit = 1'b0;
        d.hdr_valid = 1'b0;
        sel_ok = (q.sel_band >= 3'h1) && (q.sel_band <= 3'(BANDS));
        bsel = q.sel_band - 3'h1;
        // Bus answers one cycle after the request is seen.
        d.ack = (read || write) && !q.ack;
        if (idx == IDX_LOWER_BIN)
            rd = sel_ok ? {24'h000000, q.lower[q.sel_rate][bsel]} : 32'h0000_0000;
        else if (idx == IDX_UPPER_BIN)
            rd = sel_ok ? {24'h000000, q.upper[q.sel_rate][bsel]} : 32'h0000_0000;
        else if (idx == IDX_X_WARN)
            rd = {16'h0000, q.warn[0]};
        else if (idx == IDX_Y_WARN)
            rd = {16'h0000, q.warn[1]};
        else if (idx == IDX_X_FAULT)
            rd = {16'h0000, q.fault[0]};
        else if (idx == IDX_Y_FAULT)
            rd = {16'h0000, q.fault[1]};
        else if (idx == IDX_SELECTOR)
            rd = {22'h000000, q.sel_rate, 5'h00, q.sel_band};
        else if (idx == IDX_SYS_LEVEL)
            rd = {16'h0000, q.sys_level};
        else if (idx == IDX_CONFIG)
            rd = {16'h0000, q.cfg};
        else if (idx == IDX_DIAG)
            rd = {16'h0000, diag_word};
        else if (idx == IDX_X_FLAGS)
            rd = {16'h0000, q.flags[0]};
        else if (idx == IDX_Y_FLAGS)
            rd = {16'h0000, q.flags[1]};
        else if (idx == IDX_X_PEAK)
            rd = {16'h0000, q.peak[0]};
        else if (idx == IDX_Y_PEAK)
            rd = {16'h0000, q.peak[1]};
        else if (idx == IDX_X_BIN)
            rd = {24'h000000, q.wbin[0]};
        else if (idx == IDX_Y_BIN)
            rd = {24'h000000, q.wbin[1]};
        else if (idx == IDX_PIN_SELECT)
            rd = {26'h0000000, q.pin_sel};
        if (d.ack)
            d.rdata = read ? rd : 32'h0000_0000;
        // Register writes take effect on the answering edge.
        if (q.ack && write)
        begin
            if (idx == IDX_X_WARN)
                d.warn[0] = merge16(q.warn[0], writedata, byteenable);
            else if (idx == IDX_Y_WARN)
                d.warn[1] = merge16(q.warn[1], writedata, byteenable);
            else if (idx == IDX_X_FAULT)
                d.fault[0] = merge16(q.fault[0], writedata, byteenable);
            else if (idx == IDX_Y_FAULT)
                d.fault[1] = merge16(q.fault[1], writedata, byteenable);
            else if (idx == IDX_SYS_LEVEL)
                d.sys_level = merge16(q.sys_level, writedata, byteenable);
            else if (idx == IDX_CONFIG)
                d.cfg = merge16(q.cfg, writedata, byteenable) & CONFIG_MASK;
            else if (idx == IDX_SELECTOR)
            begin
                tmp = merge16({6'h00, q.sel_rate, 5'h00, q.sel_band}, writedata, byteenable);
                d.sel_band = tmp[2:0];
                d.sel_rate = tmp[SEL_RATE_LSB +: 2];
            end
            else if ((idx == IDX_LOWER_BIN) && sel_ok && byteenable[0])
                d.lower[q.sel_rate][bsel] = writedata[7:0];
            else if ((idx == IDX_UPPER_BIN) && sel_ok && byteenable[0])
                d.upper[q.sel_rate][bsel] = writedata[7:0];
            else if ((idx == IDX_PIN_SELECT) && byteenable[0])
                d.pin_sel = writedata[5:0];
            else if (idx == IDX_COMMAND)
            begin
                if (byteenable[1] && writedata[CMD_CLEAR])
                begin
                    d.lower = '0;
                    d.upper = '0;
                    d.nv_written = 1'b0;
                    d.save_ignored = 1'b0;
                    d.erase = 1'b1;
                end
                if (byteenable[1] && writedata[CMD_SAVE])
                begin
                    if (d.nv_written)
                        d.save_ignored = 1'b1;
                    else
                    begin
                        d.commit = 1'b1;
                        d.nv_written = 1'b1;
                        d.save_ignored = 1'b0;
                    end
                end
            end
        end
        // Spectral evaluation, one axis at a time.
        for (int a = 0; a < 2; a++)
        begin
            mag = (a == 0) ? spectrum.x_mag : spectrum.y_mag;
            found = 1'b0;
            best2 = 1'b0;
            bpk = 16'h0000;
            bbin = 8'h00;
            bband = 3'h0;
            fl = 16'h0000;
            for (int b = 0; b < BANDS; b++)
            begin
                mx = q.run_max[a][b];
                bn = q.run_bin[a][b];
                if (spectrum.valid && (mag > mx) &&
                    in_band(spectrum.index, q.lower[rate_option][b], q.upper[rate_option][b]))
                begin
                    mx = mag;
                    bn = spectrum.index;
                end
                d.run_max[a][b] = mx;
                d.run_bin[a][b] = bn;
                if (record_end)
                begin
                    hit1 = q.cfg[CFG_X_EN + a] && (mx > q.warn[a]);
                    hit2 = q.cfg[CFG_X_EN + a] && (mx > q.fault[a]);
                    a1 = hit1 && (q.persist[a][b][0] >= q.cfg[CFG_DELAY_LSB +: 4]);
                    a2 = hit2 && (q.persist[a][b][1] >= q.cfg[CFG_DELAY_LSB +: 4]);
                    d.persist[a][b][0] = persist_next(hit1, q.persist[a][b][0]);
                    d.persist[a][b][1] = persist_next(hit2, q.persist[a][b][1]);
                    fl[4 + 2 * b] = a1;
                    fl[5 + 2 * b] = a2;
                    if ((a1 || a2) && (!found || (a2 && !best2) || ((a2 == best2) && (mx > bpk))))
                    begin
                        found = 1'b1;
                        best2 = a2;
                        bpk = mx;
                        bbin = bn;
                        bband = 3'(b + 1);
                    end
                    d.run_max[a][b] = 16'h0000;
                    d.run_bin[a][b] = 8'h00;
                end
            end
            if (record_end)
            begin
                d.flags[a] = {fl[15:4], 1'b0, found ? bband : 3'h0};
                d.peak[a] = found ? bpk : 16'h0000;
                d.wbin[a] = found ? bbin : 8'h00;
            end
        end
        if (record_end)
        begin
            sys_val = q.cfg[CFG_SYS_TEMP] ? temperature : supply;
            d.sys_alarm = q.cfg[CFG_SYS_EN] &&
                (q.cfg[CFG_SYS_LESS] ? (sys_val < q.sys_level) : (sys_val > q.sys_level));
            d.hdr_valid = 1'b1;
        end
        d.warn_pin = d.cfg[CFG_PINS] && (d.pin_sel[PIN_WARN_LSB +: 3] == PIN_FUNC_ALARM) &&
            (|((d.flags[0][15:4] | d.flags[1][15:4]) & ALARM1_BITS));
        d.fault_pin = d.cfg[CFG_PINS] && (d.pin_sel[PIN_FAULT_LSB +: 3] == PIN_FUNC_ALARM) &&
            (|((d.flags[0][15:4] | d.flags[1][15:4]) & ALARM2_BITS));
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            q <= STATE_RESET;
        else
            q <= d;
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign waitrequest = (read || write) && !q.ack;
    assign readdata = q.rdata;
    assign header = '{diag: diag_word, x_flags: q.flags[0], y_flags: q.flags[1],
                      x_peak: q.peak[0], y_peak: q.peak[1], x_bin: q.wbin[0], y_bin: q.wbin[1]};
    assign header_valid = q.hdr_valid;
    assign nv_erase = q.erase;
    assign nv_commit = q.commit;
    assign warning_pin = q.warn_pin;
    assign fault_pin = q.fault_pin;
    assign system_alarm = q.sys_alarm;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    property p_bus_answer;
        (read || write) && waitrequest |=> !waitrequest;
    endproperty
    a_bus_answer: assert property (p_bus_answer) else $error("Bus request not answered.");

    property p_level_write;
        q.ack && write && (idx == IDX_X_WARN) && (byteenable == 4'hF)
            |=> q.warn[0] == $past(writedata[15:0]);
    endproperty
    a_level_write: assert property (p_level_write) else $error("Level write lost.");

    property p_clear;
        q.ack && write && (idx == IDX_COMMAND) && byteenable[1] && writedata[CMD_CLEAR]
            |=> (q.lower == '0) && (q.upper == '0) && nv_erase && !q.nv_written;
    endproperty
    a_clear: assert property (p_clear) else $error("Clear did not erase.");

    property p_save;
        q.ack && write && (idx == IDX_COMMAND) && byteenable[1] && writedata[CMD_SAVE] &&
            !writedata[CMD_CLEAR] && !q.nv_written |=> nv_commit ##1 !nv_commit;
    endproperty
    a_save: assert property (p_save) else $error("Save did not commit.");

    property p_ignore;
        q.ack && write && (idx == IDX_COMMAND) && byteenable[1] && writedata[CMD_SAVE] &&
            !writedata[CMD_CLEAR] && q.nv_written |=> !nv_commit && q.save_ignored;
    endproperty
    a_ignore: assert property (p_ignore) else $error("Repeated save not ignored.");

    property p_pins;
        warning_pin |-> q.cfg[CFG_PINS] &&
            (|((q.flags[0][15:4] | q.flags[1][15:4]) & ALARM1_BITS));
    endproperty
    a_pins: assert property (p_pins) else $error("Warning pin without warning.");

    property p_header;
        record_end |=> header_valid && (header.y_flags == q.flags[1]);
    endproperty
    a_header: assert property (p_header) else $error("Header not issued.");

    property p_band_number;
        (q.flags[0][15:4] != 12'h000)
            |-> (q.flags[0][2:0] >= 3'h1) && (q.flags[0][2:0] <= 3'h6) && !q.flags[0][3];
    endproperty
    a_band_number: assert property (p_band_number) else $error("Bad critical band.");

    property p_peak_ro;
        q.ack && write && (idx == IDX_X_PEAK) && !record_end |=> $stable(q.peak[0]);
    endproperty
    a_peak_ro: assert property (p_peak_ro) else $error("Peak register written.");

    property p_delay;
        record_end && (q.cfg[CFG_DELAY_LSB +: 4] != 4'h0) && (q.persist[0][0][0] == 4'h0)
            |=> !q.flags[0][4];
    endproperty
    a_delay: assert property (p_delay) else $error("Flag set before delay.");

    property p_disabled;
        record_end && !q.cfg[CFG_X_EN] |=> q.flags[0] == 16'h0000;
    endproperty
    a_disabled: assert property (p_disabled) else $error("Disabled axis flagged.");

    property p_idle_zero;
        (q.flags[0][15:4] == 12'h000) |-> (q.peak[0] == 16'h0000) && (q.wbin[0] == 8'h00);
    endproperty
    a_idle_zero: assert property (p_idle_zero) else $error("Idle axis not zero.");

    c_alarm: cover property (record_end ##1 (q.flags[0][15:4] != 12'h000));
    c_commit: cover property (nv_commit);
    c_ignored: cover property (q.save_ignored);
    c_fault_pin: cover property (fault_pin);

endmodule

// >>> verif/tb_top.sv
// Self-checking bench for the spectral band alarm monitor.
`timescale 1ns/1ps
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin error_cnt++; \
    $display("BAD %s exp %h got %h", n, e, s); end end

module tb_top;
    import band_alarm_pkg::*;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [8:0] address = '0;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [3:0] byteenable = 4'hF;
    logic [31:0] writedata = '0;
    logic [31:0] readdata;
    logic waitrequest;
    bin_in_t spectrum = '0;
    logic record_end = 1'b0;
    logic [1:0] rate_option = 2'h0;
    logic [15:0] temperature = 16'h0200;
    logic [15:0] supply = 16'h0000;
    header_t header;
    logic header_valid, nv_erase, nv_commit, warning_pin, fault_pin, system_alarm;
    int error_cnt = 0;
    int num_checks = 0;

    always #5 clock = ~clock;

    spectral_band_alarm_monitor DUT (.clock(clock), .rst(rst), .address(address), .read(read),
        .write(write), .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .spectrum(spectrum), .record_end(record_end),
        .rate_option(rate_option), .temperature(temperature), .supply(supply), .header(header),
        .header_valid(header_valid), .nv_erase(nv_erase), .nv_commit(nv_commit),
        .warning_pin(warning_pin), .fault_pin(fault_pin), .system_alarm(system_alarm));

    // ------------------------------------------------------------
    // Bus and record tasks
    // ------------------------------------------------------------
    task automatic acc(input logic wr, input logic [6:0] idx, input logic [15:0] d,
        output logic [31:0] q);
        @(posedge clock);
        read <= ~wr;
        write <= wr;
        address <= {idx, 2'b00};
        writedata <= {16'h0000, d};
        @(posedge clock);
        while (waitrequest !== 1'b0)
        begin
            @(posedge clock);
        end
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask

    task automatic wr(input logic [6:0] idx, input logic [15:0] d);
        logic [31:0] q;
        acc(1'b1, idx, d, q);
    endtask

    task automatic rchk(input string n, input logic [6:0] idx, input logic [31:0] e);
        logic [31:0] q;
        acc(1'b0, idx, 16'h0000, q);
        `CHK(n, e, q)
    endtask

    task automatic rec(input logic [7:0] idx, input logic [15:0] xm);
        @(posedge clock);
        spectrum <= '{1'b1, idx, xm, 16'h0000};
        record_end <= 1'b1;
        @(posedge clock);
        spectrum <= '0;
        record_end <= 1'b0;
        #1;
        `CHK("header_valid", 1'b1, header_valid)
    endtask

    task automatic test_done;
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Watchdog
    // ------------------------------------------------------------
    initial
    begin
        repeat (20000) @(posedge clock);
        error_cnt++;
        test_done;
    end

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial
    begin
        repeat (20) @(posedge clock);
        rst <= 1'b0;
        rchk("x_warn", IDX_X_WARN, 32'h0000_0000);
        rchk("config", IDX_CONFIG, 32'h0000_0080);
        rchk("x_peak", IDX_X_PEAK, 32'h0000_0000);
        rchk("y_bin", IDX_Y_BIN, 32'h0000_0000);
        rchk("x_flags", IDX_X_FLAGS, 32'h0000_0000);
        $display("test reset done");
        wr(IDX_X_WARN, 16'hA5C3);
        rchk("x_warn", IDX_X_WARN, 32'h0000_A5C3);
        wr(IDX_Y_FAULT, 16'h8000);
        rchk("y_fault", IDX_Y_FAULT, 32'h0000_8000);
        wr(IDX_X_PEAK, 16'h1234);
        rchk("x_peak", IDX_X_PEAK, 32'h0000_0000);
        rchk("unmapped", 7'h7F, 32'h0000_0000);
        $display("test registers done");
        wr(IDX_COMMAND, 16'h0200);
        #1 `CHK("nv_erase", 1'b1, nv_erase)
        wr(IDX_COMMAND, 16'h1000);
        #1 `CHK("nv_commit", 1'b1, nv_commit)
        wr(IDX_COMMAND, 16'h1000);
        #1 `CHK("nv_commit", 1'b0, nv_commit)
        rchk("diag", IDX_DIAG, 32'h0000_0002);
        $display("test commands done");
        wr(IDX_SELECTOR, 16'h0001);
        wr(IDX_LOWER_BIN, 16'h0005);
        wr(IDX_UPPER_BIN, 16'h0014);
        wr(IDX_X_WARN, 16'h0080);
        wr(IDX_X_FAULT, 16'h0200);
        wr(IDX_PIN_SELECT, 16'h0009);
        wr(IDX_SYS_LEVEL, 16'h0100);
        wr(IDX_CONFIG, 16'h0059);
        rec(8'h0A, 16'h0100);
        `CHK("hdr_x_peak", 16'h0100, header.x_peak)
        `CHK("warning_pin", 1'b1, warning_pin)
        `CHK("fault_pin", 1'b0, fault_pin)
        `CHK("system_alarm", 1'b1, system_alarm)
        `CHK("hdr_x_flags", 16'h0011, header.x_flags)
        rchk("x_flags", IDX_X_FLAGS, 32'h0000_0011);
        rchk("x_peak", IDX_X_PEAK, 32'h0000_0100);
        rchk("x_bin", IDX_X_BIN, 32'h0000_000A);
        rec(8'h14, 16'h0300);
        `CHK("fault_pin", 1'b1, fault_pin)
        rchk("x_flags", IDX_X_FLAGS, 32'h0000_0031);
        rchk("x_bin", IDX_X_BIN, 32'h0000_0014);
        rec(8'h15, 16'hFFFF);
        rchk("x_flags", IDX_X_FLAGS, 32'h0000_0000);
        rchk("x_peak", IDX_X_PEAK, 32'h0000_0000);
        rchk("x_bin", IDX_X_BIN, 32'h0000_0000);
        $display("test bands done");
        rate_option <= 2'h1;
        rec(8'h0A, 16'h0100);
        rchk("x_flags", IDX_X_FLAGS, 32'h0000_0000);
        rate_option <= 2'h0;
        wr(IDX_CONFIG, 16'h0058);
        rec(8'h0A, 16'h0100);
        rchk("x_flags", IDX_X_FLAGS, 32'h0000_0000);
        wr(IDX_CONFIG, 16'h0159);
        rec(8'h0A, 16'h0100);
        rchk("x_flags", IDX_X_FLAGS, 32'h0000_0000);
        rec(8'h0A, 16'h0100);
        rchk("x_flags", IDX_X_FLAGS, 32'h0000_0011);
        wr(IDX_CONFIG, 16'h0039);
        rec(8'h0A, 16'h0100);
        `CHK("system_alarm", 1'b0, system_alarm)
        `CHK("warning_pin", 1'b0, warning_pin)
        wr(IDX_CONFIG, 16'h0029);
        rec(8'h0A, 16'h0100);
        `CHK("system_alarm", 1'b1, system_alarm)
        rchk("diag", IDX_DIAG, 32'h0000_0003);
        $display("test options done");
        test_done;
    end
endmodule
